// ==== sram_bus_host.sv ====
// Purpose: Host end of the shared data lanes.
// Assumes: Host changes its drive only at the falling clock.
// Notes  : A released bus toggles so stale data never looks valid.
`timescale 1ns/1ps
module sram_bus_host
   import sram_port_pkg::*;
(
   // Clock
   input wire logic             clk_i,
   // Host side
   input wire logic             drive_i,
   input wire word_t            data_i,
   // Bus side
   input wire logic [LANES-1:0] lanes_oe_i,
   output word_t                bus_o,
   output logic                 clash_o
);
   // ==================
   // Bus level and contention
   word_t float_r = '0;
   always @(negedge clk_i) begin
      float_r <= drive_i ? ~data_i : ~float_r;
   end
   assign bus_o = drive_i ? data_i : float_r;
   // Both ends driving the lanes at one edge
   always @(posedge clk_i) begin
      clash_o <= drive_i && (lanes_oe_i != '0);
   end
endmodule

// ==== sram_port_pkg.sv ====
// Purpose : Shared constants, carriers and helpers for the burst SRAM host port.
// Assumes : One clock; all pins sampled synchronously to it.
// Notes   : Address and lane widths here fix the carrier layouts.

package sram_port_pkg;

   // ==========================================================================
   // Geometry
   localparam int ADDR_W    = 19;             // Word address width
   localparam int LANES     = 4;              // Byte lanes per word
   localparam int LANE_BITS = 8;              // Data bits per lane
   localparam int BURST_W   = 2;              // Burst counter width

   // ==========================================================================
   // Reset values and strap encodings
   localparam logic [BURST_W-1:0] BURST_RST    = 2'h0;
   localparam logic [BURST_W-1:0] BURST_STEP   = 2'h1;
   localparam logic               ORDER_LINEAR = 1'b0;  // Strap low selects linear
   localparam logic               ORDER_RST    = 1'b1;  // Interleaved until sampled
   localparam logic               PIN_RST      = 1'b0;

   // ==========================================================================
   // Carriers
   typedef struct packed {
      logic                 parity_lane;
      logic [LANE_BITS-1:0] data_lane;
   } lane_t;

   typedef lane_t [LANES-1:0]  word_t;
   typedef logic  [LANES-1:0]  mask_t;
   typedef logic  [ADDR_W-1:0] addr_t;

   typedef struct packed {
      addr_t addr;
      word_t data;
      mask_t mask;
   } wr_item_t;

   // Deselected, first cycle of a processor-strobed access, running burst
   typedef enum {ST_IDLE, ST_PROC_FIRST, ST_BURST} cyc_t;

   // ==========================================================================
   // Helpers
   // Low address bits for burst step cnt from a start offset
   function automatic logic [BURST_W-1:0] burst_low(input logic               order,
                                                    input logic [BURST_W-1:0] start,
                                                    input logic [BURST_W-1:0] cnt);
      if (order == ORDER_LINEAR) begin
         burst_low = start + cnt;
      end else begin
         burst_low = start ^ cnt;
      end
   endfunction

   // Overlay the written lanes of a pending item onto a word
   function automatic word_t merge_item(input word_t w, input wr_item_t it);
      merge_item = w;
      for (int i = 0; i < LANES; i++) begin
         if (it.mask[i]) begin
            merge_item[i] = it.data[i];
         end
      end
   endfunction

endpackage

// ==== sram_port_sva.sv ====
// Purpose: Port checks for the burst SRAM host port.
// Assumes: Outputs come from flops; enables act one edge late.
// Notes  : Bound to every instance of the port.
`timescale 1ns/1ps
module sram_port_sva
   import sram_port_pkg::*;
(
   // Clock and reset
   input wire logic             clk_i,
   input wire logic             rst_i,
   // Selects, strobes, write controls
   input wire logic             chip_select_low_a_n_i,
   input wire logic             chip_select_high_i,
   input wire logic             chip_select_low_b_n_i,
   input wire logic             proc_addr_strobe_n_i,
   input wire logic             ctrl_addr_strobe_n_i,
   input wire logic             global_write_n_i,
   input wire logic             byte_write_enable_n_i,
   input wire logic             out_enable_n_i,
   input wire logic             sleep_request_i,
   input wire logic             tck_i,
   // Watched outputs
   input wire logic [LANES-1:0] lanes_oe_o,
   input wire logic             tdo_o
);
   // ==================
   // Decoded bus state
   logic sel, strobe, quiet_rd;
   assign sel = !chip_select_low_a_n_i && chip_select_high_i && !chip_select_low_b_n_i;
   // A processor strobe counts only with the first select low
   assign strobe = !ctrl_addr_strobe_n_i || (!proc_addr_strobe_n_i && !chip_select_low_a_n_i);
   assign quiet_rd = global_write_n_i && byte_write_enable_n_i && !out_enable_n_i
                     && !sleep_request_i && proc_addr_strobe_n_i;

   default clocking @(posedge clk_i); endclocking
   default disable iff (rst_i);

   // ==================
   // Sequences and properties
   sequence s_desel; strobe && !sel; endsequence
   sequence s_start; strobe && sel; endsequence
   sequence s_rd_start; quiet_rd && sel && !ctrl_addr_strobe_n_i; endsequence
   sequence s_rd_next; quiet_rd && ctrl_addr_strobe_n_i; endsequence

   property p_oe_float; out_enable_n_i |=> lanes_oe_o == '0; endproperty
   property p_lanes_same; lanes_oe_o == '0 || lanes_oe_o == '1; endproperty
   property p_deselect; s_desel |=> lanes_oe_o == '0; endproperty
   property p_fresh; s_desel ##1 s_start |=> lanes_oe_o == '0; endproperty
   property p_write_float; !global_write_n_i && proc_addr_strobe_n_i |=> lanes_oe_o == '0;
   endproperty
   property p_sleep; sleep_request_i |=> lanes_oe_o == '0; endproperty
   property p_read_drive; s_rd_start ##1 s_rd_next |=> lanes_oe_o == '1; endproperty
   property p_tdo_fall; $changed(tdo_o) |-> !$past(tck_i); endproperty

   a_oe_float: assert property (p_oe_float)
      else $error("lanes driven while enable high");
   a_lanes_same: assert property (p_lanes_same)
      else $error("lane enables differ");
   a_deselect: assert property (p_deselect)
      else $error("lanes driven after deselect");
   a_fresh: assert property (p_fresh)
      else $error("lanes driven in first cycle from deselect");
   a_write_float: assert property (p_write_float)
      else $error("lanes driven during write");
   a_sleep: assert property (p_sleep)
      else $error("lanes driven in sleep");
   a_read_drive: assert property (p_read_drive)
      else $error("read data not driven");
   a_tdo_fall: assert property (p_tdo_fall)
      else $error("test out moved outside low test clock");
endmodule

bind sync_burst_sram_port sram_port_sva sram_port_sva_inst (
   .clk_i(clk_i), .rst_i(rst_i), .chip_select_low_a_n_i(chip_select_low_a_n_i),
   .chip_select_high_i(chip_select_high_i), .chip_select_low_b_n_i(chip_select_low_b_n_i),
   .proc_addr_strobe_n_i(proc_addr_strobe_n_i), .ctrl_addr_strobe_n_i(ctrl_addr_strobe_n_i),
   .global_write_n_i(global_write_n_i), .byte_write_enable_n_i(byte_write_enable_n_i),
   .out_enable_n_i(out_enable_n_i), .sleep_request_i(sleep_request_i), .tck_i(tck_i),
   .lanes_oe_o(lanes_oe_o), .tdo_o(tdo_o));

// ==== sync_burst_sram_host_port_tb.sv ====
// Purpose: Self-checking bench for the burst SRAM host port.
// Assumes: Inputs change at the falling clock edge.
// Notes  : Test addresses stay in one sixteen-word window.
`timescale 1ns/1ps
module sync_burst_sram_host_port_tb;
   import sram_port_pkg::*;
   // ==================
   // Pins and bench state
   logic             clk_i, rst_i, sel_a_n, sel_hi, sel_b_n, pstb_n, cstb_n, step_n;
   logic             gwr_n, bwr_n, oe_n, sleep, order, tck, tdi, tdo, full, drive, clash;
   addr_t            addr, a;
   mask_t            bsel_n;
   word_t            pins, wdata, rdata;
   logic [LANES-1:0] oe;
   word_t            mem [addr_t];
   logic [31:0]      seed;
   int               n_mismatch = 0, samples_checked = 0, cycles = 0;

   sync_burst_sram_port sync_burst_sram_port_inst (.clk_i(clk_i), .rst_i(rst_i),
      .chip_select_low_a_n_i(sel_a_n), .chip_select_high_i(sel_hi),
      .chip_select_low_b_n_i(sel_b_n), .proc_addr_strobe_n_i(pstb_n),
      .ctrl_addr_strobe_n_i(cstb_n), .burst_advance_n_i(step_n), .addr_i(addr),
      .global_write_n_i(gwr_n), .byte_write_enable_n_i(bwr_n), .byte_select_n_i(bsel_n),
      .out_enable_n_i(oe_n), .sleep_request_i(sleep), .burst_order_i(order),
      .lanes_i(pins), .lanes_o(rdata), .lanes_oe_o(oe), .wbuf_full_o(full),
      .tck_i(tck), .tdi_i(tdi), .tdo_o(tdo));
   sram_bus_host sram_bus_host_inst (.clk_i(clk_i), .drive_i(drive), .data_i(wdata),
      .lanes_oe_i(oe), .bus_o(pins), .clash_o(clash));

   // ==================
   // Clock, timeout, contention watch
   initial begin
      clk_i = 1'b0;
      forever #10 clk_i = ~clk_i;
   end
   always @(posedge clk_i) begin
      cycles++;
      if (cycles == 20000) begin
         n_mismatch++;
         conclude();
      end
   end
   always @(negedge clk_i) begin
      if (rst_i === 1'b0) check("bus clash", 0, clash);
   end

   // ==================
   // Helpers
   function automatic logic [31:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction
   function automatic word_t rword();
      logic [63:0] r;
      r = {rnd(), rnd()};
      return r[$bits(word_t)-1:0];
   endfunction
   // Expected address of burst beat k
   function automatic addr_t baddr(logic ord, addr_t s, logic [1:0] k);
      baddr = s;
      baddr[1:0] = ord ? (s[1:0] ^ k) : (s[1:0] + k);
   endfunction
   task automatic check(string what, logic [63:0] exp, logic [63:0] got);
      samples_checked++;
      if (got !== exp) begin
         n_mismatch++;
         $display("ERROR %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic conclude();
      $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
      if (n_mismatch == 0 && samples_checked > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask
   // No strobe, no write, host released: turnaround before writes
   task automatic idle();
      @(negedge clk_i);
      {pstb_n, cstb_n, step_n, gwr_n, bwr_n, oe_n, drive} = 7'h7e;
   endtask
   // One controller write per edge, so calls run back to back
   task automatic wr(addr_t w, word_t d, mask_t m, logic glob);
      @(negedge clk_i);
      {cstb_n, pstb_n, drive} = 3'h3;
      oe_n = !(glob || m != '0);
      {addr, wdata, gwr_n, bwr_n, bsel_n} = {w, d, ~glob, glob, ~m};
      for (int i = 0; i < LANES; i++) if (glob || m[i]) mem[w][i] = d[i];
   endtask
   task automatic rd(addr_t s, int beats, logic proc);
      @(negedge clk_i);
      {pstb_n, cstb_n, gwr_n, bwr_n, oe_n, drive} = {~proc, proc, 4'hc};
      addr = s;
      @(negedge clk_i);
      {pstb_n, cstb_n, step_n} = {2'h3, beats < 2};
      for (int k = 0; k < beats; k++) begin
         @(negedge clk_i);
         step_n = (k + 2 >= beats);
         check("read data", mem[baddr(order, s, k[1:0])], rdata);
         check("lane drive", {LANES{1'b1}}, oe);
      end
   endtask
   task automatic restart(logic ord);
      @(negedge clk_i);
      {rst_i, order} = {1'b1, ord};
      repeat (20) @(negedge clk_i);
      rst_i = 1'b0;
      repeat (2) @(negedge clk_i);
      check("reset outputs", 0, {oe, tdo, full, rdata});
   endtask
   task automatic bursts();
      for (int s = 0; s < 4; s++) rd(addr_t'(8'h40 + 5 * s), 4, 1'b0);
      $display("burst test done, order %0d", order);
   endtask

   // ==================
   // Main sequence
   initial begin
      seed = 32'hdac3_3e5a;
      {rst_i, sel_a_n, sel_hi, sel_b_n, sleep, tck, tdi} = 7'h50;
      {addr, bsel_n, wdata, order} = '0;
      {pstb_n, cstb_n, step_n, gwr_n, bwr_n, oe_n, drive} = 7'h7e;
      restart(1'b0);
      idle();
      for (int i = 0; i < 16; i++) wr(addr_t'(8'h40 + i), rword(), mask_t'(rnd()), 1'b1);
      for (int i = 0; i < 16; i++) wr(addr_t'(8'h40 + i), rword(), mask_t'(rnd()), 1'b0);
      for (int i = 0; i < 16; i++) rd(addr_t'(8'h40 + i), 1, i[0]);
      $display("write and read test done");
      // One select inactive at a strobe, then a start from deselect: no drive
      for (int j = 0; j < 3; j++) begin
         @(negedge clk_i);
         {sel_a_n, sel_hi, sel_b_n, cstb_n, oe_n} = {3'h2 ^ (3'h4 >> j), 2'h0};
         @(negedge clk_i);
         {sel_a_n, sel_hi, sel_b_n, cstb_n} = 4'h4;
         @(negedge clk_i);
         check("deselected", 0, oe);
      end
      // A read in progress keeps driving through an ignored strobe
      rd(19'h0_0041, 1, 1'b0);
      {sel_a_n, pstb_n} = 2'h2;
      @(negedge clk_i);
      {sel_a_n, pstb_n} = 2'h1;
      @(negedge clk_i);
      check("ignored strobe", {LANES{1'b1}}, oe);
      // Both strobes with a write: processor start reads, no write lands
      idle();
      @(negedge clk_i);
      {pstb_n, cstb_n, gwr_n, drive, addr, wdata} = {4'h1, 19'h0_0046, ~mem[19'h0_0046]};
      idle();
      rd(19'h0_0046, 1, 1'b0);
      idle();
      @(negedge clk_i);
      {pstb_n, addr} = {1'b0, 19'h0_004b};
      @(negedge clk_i);
      {pstb_n, gwr_n, drive, wdata} = {3'h5, rword()};
      mem[19'h0_004b] = wdata;
      rd(19'h0_004b, 1, 1'b1);
      @(negedge clk_i);
      sleep = 1'b1;
      repeat (3) @(negedge clk_i);
      sleep = 1'b0;
      for (int i = 0; i < 16; i++) rd(addr_t'(8'h40 + i), 1, 1'b0);
      $display("strobe and sleep test done");
      for (int i = 0; i < 40; i++) begin
         a = addr_t'(8'h40 + rnd() % 16);
         if (rnd() % 2 == 1) begin
            idle();
            wr(a, rword(), mask_t'(rnd()), rnd() % 2 == 1);
            idle();
         end else begin
            rd(a, int'(rnd() % 4) + 1, 1'b0);
         end
      end
      $display("random test done");
      bursts();
      restart(1'b1);
      bursts();
      void'(rnd());
      for (int i = 0; i < 8; i++) begin
         tdi = seed[i];
         repeat (4) @(negedge clk_i);
         tck = 1'b1;
         repeat (4) @(negedge clk_i);
         tck = 1'b0;
         repeat (4) @(negedge clk_i);
         check("test out", seed[i], tdo);
      end
      $display("test port done");
      conclude();
   end
endmodule

// ==== sync_burst_sram_port.sv ====
// Purpose : Host-facing control, burst and data port of a pipelined burst SRAM.
// Assumes : All pins synchronous to clk_i; the strap is held static by the board.
// Notes   : Output enable and sleep are sampled, so they act one edge late.
//
// Behaviour
// - first chip select active low, sampled
// - second chip select active high, sampled
// - selected only when all three active
// - processor strobe ignored while first select high
// - output enable low drives pins, high floats
// - first read cycle from deselect stays floating
// - advance input steps burst address
// - processor strobe loads address and counter
// - controller strobe loads address and counter
// - both strobes low: processor strobe wins
// - strap low linear, high interleaved order
// - sleep idles device, keeps memory contents
// - input pins captured on rising edge
// - read data follows registered address one cycle
// - lanes of eight data, one parity
// - test data out changes on falling edge
// - test data in sampled on rising edge
// - two-bit burst counter wraps within four
// - read starts: strobe, selected, writes high
// - write cycle forces data pins floating
// - global write writes every byte lane

`timescale 1ns/1ps

module sync_burst_sram_port
   import sram_port_pkg::*;
(
   // Clock and reset
   input  wire logic             clk_i,
   input  wire logic             rst_i,
   // Selects and strobes
   input  wire logic             chip_select_low_a_n_i,
   input  wire logic             chip_select_high_i,
   input  wire logic             chip_select_low_b_n_i,
   input  wire logic             proc_addr_strobe_n_i,
   input  wire logic             ctrl_addr_strobe_n_i,
   input  wire logic             burst_advance_n_i,
   input  wire addr_t            addr_i,
   // Write controls
   input  wire logic             global_write_n_i,
   input  wire logic             byte_write_enable_n_i,
   input  wire mask_t            byte_select_n_i,
   // Asynchronous-class controls and strap
   input  wire logic             out_enable_n_i,
   input  wire logic             sleep_request_i,
   input  wire logic             burst_order_i,
   // Data and parity lanes
   input  wire word_t            lanes_i,
   output word_t                 lanes_o,
   output logic [LANES-1:0]      lanes_oe_o,
   // Write buffer status
   output logic                  wbuf_full_o,
   // Test port
   input  wire logic             tck_i,
   input  wire logic             tdi_i,
   output logic                  tdo_o
);

   // ==========================================================================
   // Storage array
   word_t    mem [2**ADDR_W];

   // ==========================================================================
   // Cycle control state
   cyc_t               st_r;
   cyc_t               st_nxt;
   addr_t              addr_r;
   addr_t              addr_nxt;
   logic [BURST_W-1:0] start_r;
   logic [BURST_W-1:0] start_nxt;
   logic [BURST_W-1:0] cnt_r;
   logic [BURST_W-1:0] cnt_nxt;
   addr_t              acc_addr_r;
   addr_t              acc_addr_nxt;
   logic               rd_r;
   logic               rd_nxt;
   logic               order_r;
   logic               order_nxt;
   logic               order_seen_r;
   logic               order_seen_nxt;

   // Output stage state
   word_t              q_r;
   word_t              q_nxt;
   logic               oe_r;
   logic               oe_nxt;

   // Test port state
   logic               tck_r;
   logic               tck_nxt;
   logic               tbit_r;
   logic               tbit_nxt;
   logic               tdo_r;
   logic               tdo_nxt;

   // Decoded cycle terms
   logic               selected;
   logic               proc_go;
   logic               ctrl_go;
   logic               wr_any;
   logic               wr_go;
   logic               fresh;
   mask_t              wr_mask;
   addr_t              cyc_addr;
   wr_item_t           wr_item;

   // Buffer connections
   logic               wb_ready;
   logic               wb_out_valid;
   logic               wb_out_ready;
   wr_item_t           wb_out_item;
   logic               wb_tail_valid;
   wr_item_t           wb_tail_item;
   word_t              rd_word;

   // ==========================================================================
   // Strobe and select decode
   // Selection needs all three selects active at the same edge
   assign selected = ~chip_select_low_a_n_i
                   & chip_select_high_i
                   & ~chip_select_low_b_n_i;
   // The processor strobe is only heard while the first select is low
   assign proc_go  = ~proc_addr_strobe_n_i & ~chip_select_low_a_n_i;
   // Controller strobe loses to a heard processor strobe
   assign ctrl_go  = ~ctrl_addr_strobe_n_i & ~proc_go;
   // Any write request; without one the cycle is a read
   assign wr_any   = ~global_write_n_i
                   | (~byte_write_enable_n_i & (|(~byte_select_n_i)));
   // Global write overrides the per-lane selects
   assign wr_mask  = ~global_write_n_i ? {LANES{1'b1}} :
                     (~byte_write_enable_n_i ? ~byte_select_n_i : '0);

   // ==========================================================================
   // Cycle sequencer: address capture, burst stepping, read or write
   always_comb begin
      st_nxt       = st_r;
      addr_nxt     = addr_r;
      start_nxt    = start_r;
      cnt_nxt      = cnt_r;
      rd_nxt       = 1'b0;
      wr_go        = 1'b0;
      fresh        = 1'b0;
      if (sleep_request_i) begin
         st_nxt = ST_IDLE;
      end else if (proc_go || ctrl_go) begin
         if (selected) begin
            // Either strobe reloads the address and seeds the counter
            addr_nxt  = addr_i;
            start_nxt = addr_i[BURST_W-1:0];
            cnt_nxt   = BURST_RST;
            fresh     = (st_r == ST_IDLE);
            if (proc_go) begin
               // Write controls are not looked at in this first cycle
               st_nxt = ST_PROC_FIRST;
               rd_nxt = 1'b1;
            end else begin
               st_nxt = ST_BURST;
               wr_go  = wr_any;
               rd_nxt = ~wr_any;
            end
         end else begin
            st_nxt = ST_IDLE;
         end
      end else if (st_r != ST_IDLE) begin
         st_nxt = ST_BURST;
         // Advance is ignored on the cycle after a processor strobe
         if (st_r == ST_BURST && !burst_advance_n_i) begin
            cnt_nxt = cnt_r + BURST_STEP;
         end
         wr_go  = wr_any;
         rd_nxt = ~wr_any;
      end
   end

   // Word address of this cycle's access
   assign cyc_addr = {addr_nxt[ADDR_W-1:BURST_W],
                      burst_low(order_r, start_nxt, cnt_nxt)};
   assign acc_addr_nxt = cyc_addr;

   // The strap is caught once after reset and then held
   always_comb begin
      order_seen_nxt = 1'b1;
      order_nxt      = order_seen_r ? order_r : burst_order_i;
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         st_r         <= ST_IDLE;
         addr_r       <= '0;
         start_r      <= BURST_RST;
         cnt_r        <= BURST_RST;
         acc_addr_r   <= '0;
         rd_r         <= 1'b0;
         order_r      <= ORDER_RST;
         order_seen_r <= 1'b0;
      end else begin
         st_r         <= st_nxt;
         addr_r       <= addr_nxt;
         start_r      <= start_nxt;
         cnt_r        <= cnt_nxt;
         acc_addr_r   <= acc_addr_nxt;
         rd_r         <= rd_nxt;
         order_r      <= order_nxt;
         order_seen_r <= order_seen_nxt;
      end
   end

   // ==========================================================================
   // Write path: pins are captured into the buffer on the write edge
   assign wr_item = '{addr: cyc_addr, data: lanes_i, mask: wr_mask};

   // Drain on every awake cycle: reads see pending words by forwarding, and
   // a word left waiting in the buffer would be lost to a mid-run reset
   assign wb_out_ready = ~sleep_request_i;

   wr_buffer #(
      .item_t       (wr_item_t)
   ) u_wr_buffer (
      .clk_i        (clk_i),
      .rst_i        (rst_i),
      .in_valid_i   (wr_go),
      .in_ready_o   (wb_ready),
      .in_item_i    (wr_item),
      .out_valid_o  (wb_out_valid),
      .out_ready_i  (wb_out_ready),
      .out_item_o   (wb_out_item),
      .full_o       (wbuf_full_o),
      .tail_valid_o (wb_tail_valid),
      .tail_item_o  (wb_tail_item)
   );

   // Array update; contents are never reset or touched by sleep
   always_ff @(posedge clk_i) begin
      if (wb_out_valid && wb_out_ready) begin
         mem[wb_out_item.addr] <= merge_item(mem[wb_out_item.addr], wb_out_item);
      end
   end

   // ==========================================================================
   // Read path: array word plus any pending writes, oldest first
   always_comb begin
      rd_word = mem[acc_addr_r];
      if (wb_out_valid && wb_out_item.addr == acc_addr_r) begin
         rd_word = merge_item(rd_word, wb_out_item);
      end
      if (wb_tail_valid && wb_tail_item.addr == acc_addr_r) begin
         rd_word = merge_item(rd_word, wb_tail_item);
      end
   end

   // Output register loads the word addressed at the previous edge
   always_comb begin
      q_nxt  = rd_r ? rd_word : q_r;
      oe_nxt = rd_r & ~out_enable_n_i
             & ~wr_go
             & ~fresh
             & ~sleep_request_i
             & (st_nxt != ST_IDLE);
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         q_r  <= '0;
         oe_r <= 1'b0;
      end else begin
         q_r  <= q_nxt;
         oe_r <= oe_nxt;
      end
   end

   assign lanes_o    = q_r;
   assign lanes_oe_o = {LANES{oe_r}};

   // ==========================================================================
   // Test port: one-bit pass stage, edges seen by sampling tck_i
   always_comb begin
      tck_nxt  = tck_i;
      tbit_nxt = tbit_r;
      tdo_nxt  = tdo_r;
      if (tck_i && !tck_r) begin
         tbit_nxt = tdi_i;
      end
      if (!tck_i && tck_r) begin
         tdo_nxt = tbit_r;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         tck_r  <= PIN_RST;
         tbit_r <= PIN_RST;
         tdo_r  <= PIN_RST;
      end else begin
         tck_r  <= tck_nxt;
         tbit_r <= tbit_nxt;
         tdo_r  <= tdo_nxt;
      end
   end

   assign tdo_o = tdo_r;

endmodule

// ==== wr_buffer.sv ====
// Purpose : Two-entry valid/ready buffer between write capture and the array.
// Assumes : Single clock, synchronous active-high reset.
// Notes   : Both entries are visible so reads can see pending writes.

`timescale 1ns/1ps

module wr_buffer #(
   parameter type item_t = logic
) (
   // Clock and reset
   input  wire logic  clk_i,
   input  wire logic  rst_i,
   // Fill side
   input  wire logic  in_valid_i,
   output logic       in_ready_o,
   input  wire item_t in_item_i,
   // Drain side
   output logic       out_valid_o,
   input  wire logic  out_ready_i,
   output item_t      out_item_o,
   // Occupancy view
   output logic       full_o,
   output logic       tail_valid_o,
   output item_t      tail_item_o
);

   // ==========================================================================
   // Storage
   logic  head_v_r;
   logic  head_v_nxt;
   logic  tail_v_r;
   logic  tail_v_nxt;
   item_t head_r;
   item_t head_nxt;
   item_t tail_r;
   item_t tail_nxt;
   logic  pop;
   logic  push;

   // A full buffer still takes a word in the cycle it drains one
   assign pop          = head_v_r & out_ready_i;
   assign in_ready_o   = ~tail_v_r | pop;
   assign push         = in_valid_i & in_ready_o;
   assign out_valid_o  = head_v_r;
   assign out_item_o   = head_r;
   assign full_o       = tail_v_r;
   assign tail_valid_o = tail_v_r;
   assign tail_item_o  = tail_r;

   // Shift on pop, then place a new word in the first free slot
   always_comb begin
      head_v_nxt = head_v_r;
      tail_v_nxt = tail_v_r;
      head_nxt   = head_r;
      tail_nxt   = tail_r;
      if (pop) begin
         head_v_nxt = tail_v_r;
         head_nxt   = tail_r;
         tail_v_nxt = 1'b0;
      end
      if (push) begin
         if (!head_v_nxt) begin
            head_v_nxt = 1'b1;
            head_nxt   = in_item_i;
         end else begin
            tail_v_nxt = 1'b1;
            tail_nxt   = in_item_i;
         end
      end
   end

   // Payload needs no reset; only the valid flags do
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         head_v_r <= 1'b0;
         tail_v_r <= 1'b0;
      end else begin
         head_v_r <= head_v_nxt;
         tail_v_r <= tail_v_nxt;
      end
      head_r <= head_nxt;
      tail_r <= tail_nxt;
   end

endmodule
